// ==== hdl/pqu_regs.vh ====
// constants shared by the product/quotient unit files
`ifndef PQU_REGS_VH
`define PQU_REGS_VH

// operation codes on issueOp
`define PQU_OP_W 3
`define PQU_OP_PAIR 3'h0
`define PQU_OP_ACC_ADD 3'h1
`define PQU_OP_ACC_SUB 3'h2
`define PQU_OP_GPR 3'h3
`define PQU_OP_DIV 3'h4
`define PQU_OP_RD_UPPER 3'h5
`define PQU_OP_RD_BOTTOM 3'h6

// multiplier geometry
`define PQU_HALF_W 16

// divide early-out: iterations skipped per dividend size
`define PQU_DIV_SKIP8 5'd23
`define PQU_DIV_SKIP16 5'd15
`define PQU_DIV_SKIP24 5'd7
`define PQU_DIV_STEPS 6'd32

// divide repeat rate in cycles per dividend size; latency is one more
`define PQU_DIV_RPT8 6'd11
`define PQU_DIV_RPT16 6'd18
`define PQU_DIV_RPT24 6'd25
`define PQU_DIV_RPT32 6'd32

`endif

// ==== hdl/pqu_div_iter.v ====
// iterative one-bit-per-clock divider with dividend-size early out
`include "pqu_regs.vh"

module pqu_div_iter (
  input wire clk,
  input wire rst,
  input wire start,
  input wire signedOp,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output wire busy,
  output wire lastStep,
  output wire [31:0] quotient,
  output wire [31:0] remainder
);
  reg [5:0] cnt_r;
  reg [5:0] steps_r;
  reg [31:0] quo_r;
  reg [31:0] rem_r;
  reg [31:0] dvs_r;
  reg negQ_r;
  reg negR_r;

  wire aNeg = signedOp & dividend[31];
  wire bNeg = signedOp & divisor[31];
  wire [31:0] aMag = aNeg ? (32'h0 - dividend) : dividend;
  wire [31:0] bMag = bNeg ? (32'h0 - divisor) : divisor;
  // signed fit looks at the sign extension, unsigned at leading zeros
  wire fit8 = signedOp ? (&dividend[31:7] | ~|dividend[31:7]) : ~|dividend[31:8];
  wire fit16 = signedOp ? (&dividend[31:15] | ~|dividend[31:15]) : ~|dividend[31:16];
  wire fit24 = signedOp ? (&dividend[31:23] | ~|dividend[31:23]) : ~|dividend[31:24];

  reg [4:0] skip;
  reg [5:0] rpt;
  always @* begin
    if (fit8) begin
      skip = `PQU_DIV_SKIP8;
      rpt = `PQU_DIV_RPT8;
    end else if (fit16) begin
      skip = `PQU_DIV_SKIP16;
      rpt = `PQU_DIV_RPT16;
    end else if (fit24) begin
      skip = `PQU_DIV_SKIP24;
      rpt = `PQU_DIV_RPT24;
    end else begin
      skip = 5'h0;
      rpt = `PQU_DIV_RPT32;
    end
  end

  // restoring step: one quotient bit per clock
  wire [32:0] shifted = {rem_r, quo_r[31]};
  wire [32:0] diff = shifted - {1'b0, dvs_r};
  wire take = ~diff[32];
  wire [31:0] remNxt = take ? diff[31:0] : shifted[31:0];
  wire [31:0] quoNxt = {quo_r[30:0], take};

  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= 6'h0;
      steps_r <= 6'h0;
      quo_r <= 32'h0;
      rem_r <= 32'h0;
      dvs_r <= 32'h0;
      negQ_r <= 1'b0;
      negR_r <= 1'b0;
    end else if (start) begin
      cnt_r <= rpt;
      steps_r <= `PQU_DIV_STEPS - {1'b0, skip};
      // skipped high bits are known zero in the magnitude
      quo_r <= aMag << skip;
      rem_r <= 32'h0;
      dvs_r <= bMag;
      negQ_r <= aNeg ^ bNeg;
      negR_r <= aNeg;
    end else if (cnt_r != 6'h0) begin
      cnt_r <= cnt_r - 6'h1;
      // padding cycles come first so the result lands on the fixed repeat count
      if (cnt_r <= steps_r) begin
        quo_r <= quoNxt;
        rem_r <= remNxt;
      end
    end
  end

  assign busy = (cnt_r != 6'h0);
  assign lastStep = (cnt_r == 6'h1);
  // divide by zero gives ones in the computed quotient bits only (all 32 for a full-width dividend), negated for a negative signed dividend; no trap raised here
  assign quotient = negQ_r ? (32'h0 - quoNxt) : quoNxt;
  assign remainder = negR_r ? (32'h0 - remNxt) : remNxt;
endmodule

// ==== hdl/pqu_top.v ====
// product/quotient unit: multiply, accumulate and divide beside the integer pipeline
`include "pqu_regs.vh"

module pqu_top (
  input wire clk,
  input wire rst,
  input wire issueValid,
  input wire [`PQU_OP_W-1:0] issueOp,
  input wire issueSigned,
  input wire [31:0] operandA,
  input wire [31:0] operandB,
  output wire issueStall,
  output wire unitBusy,
  output wire [31:0] topResultWord,
  output wire [31:0] bottomResultWord,
  output wire gprValid,
  output wire [31:0] gprData
);
  reg [31:0] top_r;
  reg [31:0] bottom_r;
  reg pass2_r;
  reg [`PQU_OP_W-1:0] p2Op_r;
  reg p2Signed_r;
  reg [31:0] p2A_r;
  reg [`PQU_HALF_W-1:0] p2BHigh_r;
  reg [63:0] partial_r;
  reg gprPend_r;
  reg [31:0] gprStage_r;
  reg gprValid_r;
  reg [31:0] gprData_r;

  wire [63:0] pair = {top_r, bottom_r};

  // op decode
  wire isPairMul = (issueOp == `PQU_OP_PAIR) | (issueOp == `PQU_OP_ACC_ADD) |
    (issueOp == `PQU_OP_ACC_SUB);
  wire isMul = isPairMul | (issueOp == `PQU_OP_GPR);
  wire isDiv = (issueOp == `PQU_OP_DIV);
  wire isRead = (issueOp == `PQU_OP_RD_UPPER) | (issueOp == `PQU_OP_RD_BOTTOM);

  // operand_b size check; operand_a never counts
  wire bShort = issueSigned ? (&operandB[31:15] | ~|operandB[31:15]) :
    ~|operandB[31:16];

  // divider
  wire divBusy;
  wire divLast;
  wire [31:0] divQuo;
  wire [31:0] divRem;

  // stall sources; only a new divide may chase the last divide step
  wire divStall = divBusy & ~(isDiv & divLast);
  // a read would collide with a pending product_to_gpr on the gpr port
  wire readStall = isRead & gprPend_r;
  assign issueStall = issueValid & (pass2_r | divStall | readStall);
  wire accept = issueValid & ~issueStall;

  pqu_div_iter pqu_div_iter_i (
    .clk(clk),
    .rst(rst),
    .start(accept & isDiv),
    .signedOp(issueSigned),
    .dividend(operandA),
    .divisor(operandB),
    .busy(divBusy),
    .lastStep(divLast),
    .quotient(divQuo),
    .remainder(divRem)
  );

  // one shared 33x17 signed multiplier, used twice for full-width operand_b
  wire signedNow = pass2_r ? p2Signed_r : issueSigned;
  wire [31:0] mulAIn = pass2_r ? p2A_r : operandA;
  wire [32:0] mulA = {signedNow & mulAIn[31], mulAIn};
  wire [16:0] mulB = pass2_r ? {p2Signed_r & p2BHigh_r[15], p2BHigh_r} :
    {bShort & issueSigned & operandB[15], operandB[15:0]};
  wire signed [49:0] prodRaw = $signed(mulA) * $signed(mulB);
  wire [63:0] prod = {{14{prodRaw[49]}}, prodRaw};

  // second pass adds the high half shifted over the first pass
  wire [63:0] fullProd = partial_r + {prod[47:0], 16'h0};
  wire [63:0] finalProd = pass2_r ? fullProd : prod;
  wire [`PQU_OP_W-1:0] finalOp = pass2_r ? p2Op_r : issueOp;
  wire finishing = pass2_r | (accept & isMul & bShort);

  reg [63:0] pairNxt;
  always @* begin
    case (finalOp)
      `PQU_OP_ACC_ADD: pairNxt = pair + finalProd;
      `PQU_OP_ACC_SUB: pairNxt = pair - finalProd;
      default: pairNxt = finalProd;
    endcase
  end

  // no stall input: the unit advances on its own every clock
  always @(posedge clk) begin
    if (rst) begin
      top_r <= 32'h0;
      bottom_r <= 32'h0;
    end else if (divBusy & divLast) begin
      top_r <= divRem;
      bottom_r <= divQuo;
    end else if (finishing & (finalOp != `PQU_OP_GPR)) begin
      top_r <= pairNxt[63:32];
      bottom_r <= pairNxt[31:0];
    end
  end

  // second-pass bookkeeping for full-width operand_b
  always @(posedge clk) begin
    if (rst) begin
      pass2_r <= 1'b0;
      p2Op_r <= `PQU_OP_PAIR;
      p2Signed_r <= 1'b0;
      p2A_r <= 32'h0;
      p2BHigh_r <= 16'h0;
      partial_r <= 64'h0;
    end else if (accept & isMul & ~bShort) begin
      pass2_r <= 1'b1;
      p2Op_r <= issueOp;
      p2Signed_r <= issueSigned;
      p2A_r <= operandA;
      p2BHigh_r <= operandB[31:16];
      partial_r <= prod;
    end else begin
      pass2_r <= 1'b0;
    end
  end

  // product_to_gpr gets an extra stage; reads go out straight away
  always @(posedge clk) begin
    if (rst) begin
      gprPend_r <= 1'b0;
      gprStage_r <= 32'h0;
      gprValid_r <= 1'b0;
      gprData_r <= 32'h0;
    end else begin
      gprPend_r <= finishing & (finalOp == `PQU_OP_GPR);
      if (finishing & (finalOp == `PQU_OP_GPR)) begin
        gprStage_r <= finalProd[31:0];
      end
      if (gprPend_r) begin
        gprValid_r <= 1'b1;
        gprData_r <= gprStage_r;
      end else if (accept & isRead) begin
        gprValid_r <= 1'b1;
        gprData_r <= (issueOp == `PQU_OP_RD_UPPER) ? top_r : bottom_r;
      end else begin
        gprValid_r <= 1'b0;
      end
    end
  end

  assign unitBusy = divBusy | pass2_r | gprPend_r;
  assign topResultWord = top_r;
  assign bottomResultWord = bottom_r;
  assign gprValid = gprValid_r;
  assign gprData = gprData_r;
endmodule

// ==== sim/pqu_top_props.sv ====
// assertions and covers on the product/quotient unit ports
`include "pqu_regs.vh"
module pqu_top_props (
  input wire clk,
  input wire rst,
  input wire issueValid,
  input wire [`PQU_OP_W-1:0] issueOp,
  input wire issueSigned,
  input wire [31:0] operandA,
  input wire [31:0] operandB,
  input wire issueStall,
  input wire unitBusy,
  input wire [31:0] topResultWord,
  input wire [31:0] bottomResultWord,
  input wire gprValid,
  input wire [31:0] gprData
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take = issueValid && !issueStall;
  wire sgn = issueSigned;
  wire shortB = sgn ? operandB[31:15] == {17{operandB[15]}} : operandB[31:16] == 16'h0;
  wire fits8 = sgn ? operandA[31:7] == {25{operandA[7]}} : operandA[31:8] == 24'h0;
  // sign-extend then multiply unsigned: low 64 bits equal the signed product
  wire [63:0] prod = sgn ? {{32{operandA[31]}}, operandA} * {{32{operandB[31]}}, operandB}
    : {32'h0, operandA} * {32'h0, operandB};
  wire [31:0] prodLow = prod[31:0];
  wire [63:0] pair = {topResultWord, bottomResultWord};
  wire tPair = take && issueOp == `PQU_OP_PAIR;
  wire tAdd = take && issueOp == `PQU_OP_ACC_ADD;
  wire tGpr = take && issueOp == `PQU_OP_GPR;
  wire tDiv = take && issueOp == `PQU_OP_DIV;
  wire tMul = take && issueOp <= `PQU_OP_GPR;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  short_mul_a: assert property (tPair && shortB |=> pair == $past(prod))
    else $error("short product wrong");
  full_mul_a: assert property (tPair && !shortB |-> ##2 pair == $past(prod, 2))
    else $error("full product wrong");
  full_stall_a: assert property (tMul && !shortB |=> unitBusy && (issueStall || !issueValid))
    else $error("no stall after full multiply");
  acc_add_a: assert property (tAdd && shortB |=> pair == $past(pair) + $past(prod))
    else $error("accumulate wrong");
  gpr_short_a: assert property (tGpr && shortB |-> ##2 gprValid && gprData == $past(prodLow, 2))
    else $error("register product late or wrong");
  read_top_a: assert property (take && issueOp == `PQU_OP_RD_UPPER |=> gprValid && gprData == $past(topResultWord))
    else $error("upper word read late");
  div_busy_a: assert property (tDiv |=> unitBusy [*8])
    else $error("divide not busy");
  div_short_a: assert property (tDiv && fits8 |-> ##11 unitBusy ##1 (!unitBusy || $past(issueValid)))
    else $error("short divide latency wrong");
  cover property (tDiv && !fits8);
  cover property (tMul && !shortB);
  cover property (tAdd);
endmodule

bind pqu_top pqu_top_props pqu_top_props_i (.clk(clk), .rst(rst), .issueValid(issueValid),
  .issueOp(issueOp), .issueSigned(issueSigned), .operandA(operandA), .operandB(operandB),
  .issueStall(issueStall), .unitBusy(unitBusy), .topResultWord(topResultWord),
  .bottomResultWord(bottomResultWord), .gprValid(gprValid), .gprData(gprData));

// ==== sim/pqu_issuer.sv ====
// integer pipeline model offering operations to the unit
module pqu_issuer (
  input wire clk,
  input wire issueStall,
  output logic issueValid = 1'b0,
  output logic [2:0] issueOp = 3'h0,
  output logic issueSigned = 1'b0,
  output logic [31:0] operandA = 32'h0,
  output logic [31:0] operandB = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int waits;
  // request held until an edge samples no stall; call only at a clock edge
  task automatic issue(input logic [2:0] op, input logic s, input logic [31:0] a, b,
    input logic hold);
    {issueValid, issueOp, issueSigned, operandA, operandB} <= {1'b1, op, s, a, b};
    waits = 0;
    do begin
      @(posedge clk);
      waits++;
    end while (issueStall && waits < 100);
    // released operands flip so a stale value never looks valid
    if (!hold)
      {issueValid, operandA, operandB} <= {1'b0, ~a, ~b};
  endtask
endmodule

// ==== sim/pqu_top_bench.sv ====
// self-checking bench for the product/quotient unit
`include "pqu_regs.vh"
module pqu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire issueValid, issueSigned, issueStall, unitBusy, gprValid;
  wire [2:0] issueOp;
  wire [31:0] operandA, operandB, topResultWord, bottomResultWord, gprData;
  int mismatches = 0;
  int checks_done = 0;
  logic [63:0] pr = 64'h0;
  always #5 clk = ~clk;
  pqu_top pqu_top_i (.clk(clk), .rst(rst), .issueValid(issueValid), .issueOp(issueOp),
    .issueSigned(issueSigned), .operandA(operandA), .operandB(operandB),
    .issueStall(issueStall), .unitBusy(unitBusy), .topResultWord(topResultWord),
    .bottomResultWord(bottomResultWord), .gprValid(gprValid), .gprData(gprData));
  pqu_issuer pqu_issuer_i (.clk(clk), .issueStall(issueStall), .issueValid(issueValid),
    .issueOp(issueOp), .issueSigned(issueSigned), .operandA(operandA), .operandB(operandB));
  function automatic logic [63:0] mul(input logic s, input logic [31:0] a, b);
    mul = s ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
  endfunction
  function automatic logic [63:0] res(input logic [2:0] c, input logic s,
    input logic [31:0] a, b, input logic [63:0] p0);
    case (c)
      `PQU_OP_PAIR: res = mul(s, a, b);
      `PQU_OP_ACC_ADD: res = p0 + mul(s, a, b);
      `PQU_OP_ACC_SUB: res = p0 - mul(s, a, b);
      `PQU_OP_DIV: res = s ? {$signed(a) % $signed(b), $signed(a) / $signed(b)} : {a % b, a / b};
      default: res = p0;
    endcase
  endfunction
  function automatic logic [31:0] sh(input logic [31:0] x, input int k);
    sh = $signed(x << (24 - 8 * k)) >>> (24 - 8 * k);
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input logic g);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((g ? gprValid !== 1'b1 : unitBusy !== 1'b0) && n < 40);
    if (n >= 40) begin
      mismatches++;
      finish_test;
    end
  endtask
  task automatic iss(input logic [2:0] c, input logic s, input logic [31:0] a, b, input logic h);
    pqu_issuer_i.issue(c, s, a, b, h);
    if (pqu_issuer_i.waits >= 100) begin
      mismatches++;
      finish_test;
    end
  endtask
  task automatic op(input logic [2:0] c, input logic s, input logic [31:0] a, b);
    logic [63:0] m;
    logic [31:0] g;
    m = mul(s, a, b);
    g = c == `PQU_OP_RD_UPPER ? pr[63:32] : c == `PQU_OP_RD_BOTTOM ? pr[31:0] : m[31:0];
    iss(c, s, a, b, 1'b0);
    pr = res(c, s, a, b, pr);
    if (c == `PQU_OP_GPR || c == `PQU_OP_RD_UPPER || c == `PQU_OP_RD_BOTTOM) begin
      wt(1'b1);
      check("gprData", {32'h0, g}, {32'h0, gprData});
    end
    wt(1'b0);
    check("pair", pr, {topResultWord, bottomResultWord});
  endtask
  // two requests back to back: the second shows the cycles between the two issues in waits
  task automatic run2(input logic [2:0] c1, c2, input logic [31:0] a, b, input int r);
    iss(c1, 1'b1, a, b, 1'b1);
    iss(c2, 1'b1, a, b, 1'b0);
    check("waits", r, pqu_issuer_i.waits);
    pr = res(c2, 1'b1, a, b, res(c1, 1'b1, a, b, pr));
    wt(1'b0);
    check("pair", pr, {topResultWord, bottomResultWord});
  endtask
  initial begin
    logic [31:0] a, b;
    a = $urandom(67944);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    run2(`PQU_OP_PAIR, `PQU_OP_PAIR, 32'h8765_4321, 32'h0000_7fff, 1);
    run2(`PQU_OP_PAIR, `PQU_OP_ACC_ADD, 32'h8765_4321, 32'h0001_0000, 2);
    run2(`PQU_OP_GPR, `PQU_OP_GPR, 32'hffff_fff3, 32'hffff_8000, 1);
    run2(`PQU_OP_DIV, `PQU_OP_PAIR, 32'h0000_0040, 32'h0000_0007, 12);
    for (int k = 0; k < 4; k++)
      run2(`PQU_OP_DIV, `PQU_OP_DIV, 32'h40 << (8 * k), 32'hffff_fffd, 11 + 7 * k);
    for (int i = 0; i < 60; i++) begin
      a = sh($urandom, $urandom % 4);
      b = sh($urandom, $urandom % 4);
      // low bits forced: divisor never zero nor minus one
      op(3'($urandom % 7), 1'($urandom), a, {b[31:2], 2'b10});
    end
    finish_test;
  end
endmodule
